// [core/pced_pkg.sv]
// pced_pkg: register map, reset values and sizes for the pin change interrupt block
// assumes a 32-bit axi4-lite register bus with one register per aligned word
package pced_pkg;
	localparam int          PCED_PIN_W        = 8;
	localparam int          PCED_ADDR_W       = 6;
	localparam logic [5:0]  PCED_OFF_RISE     = 6'h00;
	localparam logic [5:0]  PCED_OFF_FALL     = 6'h04;
	localparam logic [5:0]  PCED_OFF_FLAGS    = 6'h08;
	localparam logic [5:0]  PCED_OFF_CTRL     = 6'h0c;
	localparam logic [5:0]  PCED_OFF_IRQ_STAT = 6'h10;
	localparam logic [5:0]  PCED_OFF_IRQ_EN   = 6'h14;
	localparam logic [5:0]  PCED_OFF_IRQ_CLR  = 6'h18;
	localparam logic [5:0]  PCED_OFF_PINS     = 6'h1c;
	localparam logic [7:0]  PCED_RST_BYTE     = 8'h00;
	localparam logic [1:0]  PCED_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  PCED_RESP_SLVERR  = 2'h2;
	// ctrl bits
	localparam int          PCED_CTRL_MIE     = 0;
	localparam int          PCED_CTRL_SUM     = 1;
	localparam int          PCED_CTRL_SLEEP   = 2;
	// irq status bits
	localparam int          PCED_IRQ_W        = 2;
	localparam int          PCED_IRQ_CHANGE   = 0;
	localparam int          PCED_IRQ_WAKE     = 1;
	localparam int          PCED_SYNC_STAGES  = 2;
endpackage

// [core/pced_sync.sv]
// pced_sync: two-flop synchroniser for one pin
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module pced_sync (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// pin and synchronised level
	input  wire logic pin_in,
	output logic      pin_sync
);
	import pced_pkg::*;
	logic meta_q;
	// meta_q feeds only the second flop
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_q   <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule

// [core/pced_edge.sv]
// pced_edge: edge detector on one synchronised pin
// assumes the input is already on mclk
`timescale 1ns/1ps
module pced_edge (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// level in, enables and detect pulse out
	input  wire logic level,
	input  wire logic rise_en,
	input  wire logic fall_en,
	output logic      hit
);
	import pced_pkg::*;
	logic prev_q;
	logic primed_q;
	// first sample after reset only primes, so a pin held high gives no false rise
	always_ff @(posedge mclk) begin
		if (reset) begin
			prev_q   <= 1'b0;
			primed_q <= 1'b0;
		end else begin
			prev_q   <= level;
			primed_q <= 1'b1;
		end
	end
	always_comb begin
		hit = primed_q & ((rise_en & level & ~prev_q) | (fall_en & ~level & prev_q));
	end
endmodule

// [core/pced_top.sv]
// pced_top: per-pin change interrupt for one port, axi4-lite registers
// assumes pins are asynchronous; sleep state comes from the power controller on mclk
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module pced_top #(
	parameter int PIN_W = pced_pkg::PCED_PIN_W
) (
	// clock and reset
	input  wire logic                           mclk,
	input  wire logic                           reset,
	// axi4-lite write address
	input  wire logic [pced_pkg::PCED_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	// axi4-lite read address
	input  wire logic [pced_pkg::PCED_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	// port pins and power
	input  wire logic [PIN_W-1:0]               porta_pin,
	input  wire logic                           sleep_active,
	// interrupt and wake outputs
	output logic                                irq,
	output logic                                wake_req
);
	import pced_pkg::*;

	logic [PIN_W-1:0] pin_sync;
	logic [PIN_W-1:0] hit;
	logic [PIN_W-1:0] rise_en_q;
	logic [PIN_W-1:0] fall_en_q;
	logic [PIN_W-1:0] flags_q;
	logic             master_en_q;
	logic [PCED_IRQ_W-1:0] irq_stat_q;
	logic [PCED_IRQ_W-1:0] irq_en_q;
	logic [PCED_IRQ_W-1:0] irq_ev;
	logic             summary;
	logic             change_q;

	// write channel state
	logic [PCED_ADDR_W-1:0] aw_addr_q;
	logic             aw_have_q;
	logic [31:0]      w_data_q;
	logic [3:0]       w_strb_q;
	logic             w_have_q;
	logic             wr_fire;
	logic             wr_lane0;
	logic             wr_hit;
	// per-register write strobes and next values
	logic             wr_rise;
	logic             wr_fall;
	logic             wr_flags;
	logic             wr_ctrl;
	logic             wr_irq_en;
	logic             wr_irq_clr;
	logic             any_hit;
	logic             rd_take;
	logic [PIN_W-1:0] flags_d;
	logic [PCED_IRQ_W-1:0] irq_stat_d;
	logic [31:0]      rd_data_d;
	logic [1:0]       rd_resp_d;

	// one synchroniser and detector per pin
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_pin
			pced_sync u_sync (
				.mclk     (mclk),
				.reset    (reset),
				.pin_in   (porta_pin[gi]),
				.pin_sync (pin_sync[gi])
			);
			pced_edge u_edge (
				.mclk    (mclk),
				.reset   (reset),
				.level   (pin_sync[gi]),
				.rise_en (rise_en_q[gi]),
				.fall_en (fall_en_q[gi]),
				.hit     (hit[gi])
			);
		end
	endgenerate

	// write address and data may arrive in either order
	assign wr_fire  = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign wr_lane0 = w_strb_q[0];

	// address ready pulses once; a held address blocks a second one
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	// data ready works the same way, independent of the address
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			w_have_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	always_comb begin
		case (aw_addr_q)
			PCED_OFF_RISE, PCED_OFF_FALL, PCED_OFF_FLAGS, PCED_OFF_CTRL,
			PCED_OFF_IRQ_STAT, PCED_OFF_IRQ_EN, PCED_OFF_IRQ_CLR, PCED_OFF_PINS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// response stands until bready; no new write fires meanwhile
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_bresp <= PCED_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bresp <= wr_hit ? PCED_RESP_OKAY : PCED_RESP_SLVERR;
		end
	end

	// one strobe per writable register, none for irq status or pins; only byte lane 0 carries data
	assign wr_rise    = wr_fire & wr_lane0 & (aw_addr_q == PCED_OFF_RISE);
	assign wr_fall    = wr_fire & wr_lane0 & (aw_addr_q == PCED_OFF_FALL);
	assign wr_flags   = wr_fire & wr_lane0 & (aw_addr_q == PCED_OFF_FLAGS);
	assign wr_ctrl    = wr_fire & wr_lane0 & (aw_addr_q == PCED_OFF_CTRL);
	assign wr_irq_en  = wr_fire & wr_lane0 & (aw_addr_q == PCED_OFF_IRQ_EN);
	assign wr_irq_clr = wr_fire & wr_lane0 & (aw_addr_q == PCED_OFF_IRQ_CLR);
	assign any_hit    = |hit;
	assign rd_take    = s_axi_arvalid & s_axi_arready;

	// rising enables; any subset of pins may be armed
	always_ff @(posedge mclk) begin
		if (reset) begin
			rise_en_q <= PCED_RST_BYTE[PIN_W-1:0];
		end else if (wr_rise) begin
			rise_en_q <= w_data_q[PIN_W-1:0];
		end
	end

	// falling enables
	always_ff @(posedge mclk) begin
		if (reset) begin
			fall_en_q <= PCED_RST_BYTE[PIN_W-1:0];
		end else if (wr_fall) begin
			fall_en_q <= w_data_q[PIN_W-1:0];
		end
	end

	// master enable gates new interrupt events, the change level and wake, never detection or logged status
	always_ff @(posedge mclk) begin
		if (reset) begin
			master_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			master_en_q <= w_data_q[PCED_CTRL_MIE];
		end
	end

	// irq enable, same layout as irq status
	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_en_q <= '0;
		end else if (wr_irq_en) begin
			irq_en_q <= w_data_q[PCED_IRQ_W-1:0];
		end
	end

	// flags: a written zero clears, a detect in the same cycle wins
	always_comb begin
		flags_d = flags_q | hit;
		if (wr_flags) begin
			flags_d = (flags_q & w_data_q[PIN_W-1:0]) | hit;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			flags_q <= PCED_RST_BYTE[PIN_W-1:0];
		end else begin
			flags_q <= flags_d;
		end
	end

	assign summary = |flags_q;

	// change interrupt only with master enable; detection runs regardless
	assign irq_ev[PCED_IRQ_CHANGE] = master_en_q & any_hit;
	// wake event logged in the same cycle as the flag it comes from
	assign irq_ev[PCED_IRQ_WAKE]   = master_en_q & sleep_active & any_hit;

	// a written one clears a status bit; a new event in that cycle wins
	always_comb begin
		irq_stat_d = irq_stat_q | irq_ev;
		if (wr_irq_clr) begin
			irq_stat_d = (irq_stat_q & ~w_data_q[PCED_IRQ_W-1:0]) | irq_ev;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	// level while any set flag and master enable stand
	always_ff @(posedge mclk) begin
		if (reset) begin
			change_q <= 1'b0;
		end else begin
			change_q <= master_en_q & summary;
		end
	end

	// enabled sticky status, or the live change level
	always_ff @(posedge mclk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_en_q) | change_q;
		end
	end

	// raised one cycle after the flag, so the flag leads the wake
	always_ff @(posedge mclk) begin
		if (reset) begin
			wake_req <= 1'b0;
		end else begin
			wake_req <= sleep_active & master_en_q & summary;
		end
	end

	// read decode straight off the bus; the address stands until arready
	always_comb begin
		rd_data_d = '0;
		rd_resp_d = PCED_RESP_OKAY;
		case (s_axi_araddr)
			PCED_OFF_RISE:     rd_data_d[PIN_W-1:0] = rise_en_q;
			PCED_OFF_FALL:     rd_data_d[PIN_W-1:0] = fall_en_q;
			PCED_OFF_FLAGS:    rd_data_d[PIN_W-1:0] = flags_q;
			PCED_OFF_CTRL: begin
				rd_data_d[PCED_CTRL_MIE]   = master_en_q;
				rd_data_d[PCED_CTRL_SUM]   = summary;
				rd_data_d[PCED_CTRL_SLEEP] = sleep_active;
			end
			PCED_OFF_IRQ_STAT: rd_data_d[PCED_IRQ_W-1:0] = irq_stat_q;
			PCED_OFF_IRQ_EN:   rd_data_d[PCED_IRQ_W-1:0] = irq_en_q;
			PCED_OFF_IRQ_CLR:  rd_data_d = '0;
			PCED_OFF_PINS:     rd_data_d[PIN_W-1:0] = pin_sync;
			default:           rd_resp_d = PCED_RESP_SLVERR;
		endcase
	end

	// one read at a time: no new address while data waits
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// data and response stand until the next accepted address
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_axi_rdata <= '0;
			s_axi_rresp <= PCED_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rdata <= rd_data_d;
			s_axi_rresp <= rd_resp_d;
		end
	end
endmodule

// [tb/pced_props.sv]
// pced_props: bus and wake checks on pced_top ports
// assumes one mclk domain with synchronous active-high reset
`timescale 1ns/1ps
module pced_props (
	// clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// bus handshakes
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// power and interrupt
	input wire logic        sleep_active,
	input wire logic        irq,
	input wire logic        wake_req
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	AST_R_ANSWER: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read answer missing");
	AST_R_HOLD: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready too long");
	AST_W_PULSE: assert property (s_axi_wready |=> !s_axi_wready)
		else $error("wready too long");
	AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_WAKE_SLEEP: assert property (wake_req |-> $past(sleep_active))
		else $error("wake while awake");
	AST_WAKE_IRQ: assert property (wake_req |-> ##[0:3] irq)
		else $error("wake without interrupt");
endmodule

// [tb/pced_pins_model.sv]
// pced_pins_model: outside circuit driving the port pins
// assumes the bench sets wanted levels; pins move off the clock edge
`timescale 1ns/1ps
module pced_pins_model (
	// clock
	input  wire logic       mclk,
	// wanted levels and driven pins
	input  wire logic [7:0] want,
	output logic      [7:0] porta_pin
);
	// late change, 3 ns after each edge, keeps the pins away from the sampling edge
	always @(posedge mclk)
		porta_pin <= #3 want;
endmodule

// [tb/testbench.sv]
// testbench: register, edge and interrupt tests for pced_top
// assumes the pin model and checker files are compiled first
`timescale 1ns/1ps
module testbench;
	import pced_pkg::*;
	logic        mclk = 0, reset = 1, sleep_active = 0;
	logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        irq, wake_req;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
	logic [7:0]  want = 8'h00, porta_pin;
	int          n_mismatch = 0, compares = 0;
	pced_top DUT (.*);
	pced_pins_model PINS (.mclk, .want, .porta_pin);
	always #10 mclk = ~mclk;
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		br = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		r = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		chk(r, e);
	endtask
	task pin(input logic [7:0] v);
		@(posedge mclk);
		want <= v;
		repeat (8) @(posedge mclk);
	endtask
	task wt;
		repeat (4) @(posedge mclk);
	endtask
	task test_done;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// generous limit: the whole run needs well under a thousand cycles
	initial begin
		#200000;
		n_mismatch++;
		test_done;
	end
	initial begin
		repeat (20) @(posedge mclk);
		reset <= 0;
		rd(6'h00, 32'h0);
		rd(6'h04, 32'h0);
		rd(6'h08, 32'h0);
		wr(6'h00, 32'h05);
		wr(6'h04, 32'h06);
		rd(6'h00, 32'h05);
		rd(6'h04, 32'h06);
		chk({30'h0, br}, {30'h0, PCED_RESP_OKAY});
		// lane 0 off: the write is answered but changes nothing
		s_axi_wstrb <= 4'he;
		wr(6'h00, 32'hff);
		s_axi_wstrb <= 4'hf;
		rd(6'h00, 32'h05);
		pin(8'h07);
		rd(6'h08, 32'h05);
		chk({31'h0, irq}, 32'h0);
		rd(6'h0c, 32'h02);
		pin(8'h00);
		rd(6'h08, 32'h07);
		wr(6'h08, 32'hfe);
		rd(6'h08, 32'h06);
		wr(6'h08, 32'h00);
		// the clearing write lands at the same edge as the pin 0 detect
		fork
			pin(8'h01);
			begin
				@(posedge mclk);
				wr(6'h08, 32'h00);
			end
		join
		rd(6'h08, 32'h01);
		wr(6'h0c, 32'h01);
		wt;
		chk({31'h0, irq}, 32'h1);
		sleep_active <= 1;
		wt;
		chk({31'h0, wake_req}, 32'h1);
		pin(8'h05);
		rd(6'h08, 32'h05);
		rd(6'h1c, 32'h05);
		rd(6'h10, 32'h03);
		sleep_active <= 0;
		wr(6'h08, 32'h00);
		wr(6'h0c, 32'h00);
		wt;
		chk({31'h0, irq}, 32'h0);
		rd(6'h0c, 32'h00);
		wr(6'h14, 32'h01);
		wt;
		chk({31'h0, irq}, 32'h1);
		wr(6'h14, 32'h00);
		wt;
		chk({31'h0, irq}, 32'h0);
		wr(6'h18, 32'h03);
		rd(6'h10, 32'h00);
		rd(6'h20, 32'h00);
		chk({30'h0, rr}, {30'h0, PCED_RESP_SLVERR});
		wr(6'h20, 32'h00);
		chk({30'h0, br}, {30'h0, PCED_RESP_SLVERR});
		test_done;
	end
endmodule
bind pced_top pced_props chk (.*);
